/* verilog/bkreg_map.vh */
// register offsets, field positions and timing counts of the buck bank
// assumes an 8-bit register port with byte addresses as printed
`ifndef BKREG_MAP_VH
`define BKREG_MAP_VH
`define BKREG_ADDR_B1_CTRL      8'h35
`define BKREG_ADDR_B1_ILIM      8'h36
`define BKREG_ADDR_B2_RUN_V     8'h38
`define BKREG_ADDR_B2_STBY_V    8'h39
`define BKREG_ADDR_B2_SLP_V     8'h3A
`define BKREG_ADDR_B2_CTRL      8'h3B
// control register fields
`define BKREG_CTRL_RUN_EN       0
`define BKREG_CTRL_STBY_EN      1
`define BKREG_CTRL_SLP_EN       2
`define BKREG_CTRL_LPWR         3
`define BKREG_CTRL_SLEW         4
`define BKREG_CTRL_FPWM_DN      5
`define BKREG_CTRL_FPWM         6
`define BKREG_CTRL_RDIS_OFF     7
// current limit / timing register
`define BKREG_ILIM_MASK         8'h13
`define BKREG_VOLT_MASK         8'h3F
`define BKREG_ILIM_TMODE        4
// slew: one 12.5 mV step per 2 us or 4 us
`define BKREG_CLK_MHZ           100
`define BKREG_SLEW_FAST_US      2
`define BKREG_SLEW_SLOW_US      4
`define BKREG_SLEW_FAST_CYC     (`BKREG_SLEW_FAST_US * `BKREG_CLK_MHZ)
`define BKREG_SLEW_SLOW_CYC     (`BKREG_SLEW_SLOW_US * `BKREG_CLK_MHZ)
// power modes
`define BKREG_MODE_RUN          2'h0
`define BKREG_MODE_STBY         2'h1
`define BKREG_MODE_SLP          2'h2
`endif

/* verilog/bkreg_ramp.v */
// voltage-scaling ramp: steps a code one lsb per slew interval
// assumes target comes from registers on the same clock
`timescale 1ns/100ps
`include "bkreg_map.vh"
module bkreg_ramp #(
    parameter W = 6
) (
    input  wire         clock,
    input  wire         srst,
    input  wire         load,
    input  wire [W-1:0] target,
    input  wire         slow,
    output reg  [W-1:0] code_q,
    output reg          down_q
);
    // interval end counts; both fit ten bits at 100 MHz
    localparam integer FAST_I = `BKREG_SLEW_FAST_CYC - 1;
    localparam integer SLOW_I = `BKREG_SLEW_SLOW_CYC - 1;
    localparam [9:0] FAST_END = FAST_I[9:0];
    localparam [9:0] SLOW_END = SLOW_I[9:0];
    reg  [9:0] cnt_q;
    wire [9:0] period;
    assign period = slow ? SLOW_END : FAST_END;
    // ----------------------------------------------------------
    // step toward target
    // ----------------------------------------------------------
    // load jumps straight to the fused value, no ramp after reset
    always @(posedge clock) begin
        if (srst) begin
            code_q <= {W{1'b0}};
            down_q <= 1'b0;
            cnt_q  <= 10'h000;
        end else if (load) begin
            code_q <= target;
            down_q <= 1'b0;
            cnt_q  <= 10'h000;
        end else if (code_q == target) begin
            down_q <= 1'b0;
            cnt_q  <= 10'h000;
        end else if (cnt_q >= period) begin
            cnt_q  <= 10'h000;
            down_q <= (target < code_q);
            if (target < code_q) begin
                code_q <= code_q - 1'b1;
            end else begin
                code_q <= code_q + 1'b1;
            end
        end else begin
            cnt_q  <= cnt_q + 10'h001;
            down_q <= (target < code_q);
        end
    end
endmodule

/* verilog/bkreg_top.v */
// buck regulator control register bank for two bucks
// assumes register port and fuse values are on clock; mode pins async
`timescale 1ns/100ps
`include "bkreg_map.vh"
// Operation
// - low-power bit acts in standby or sleep
// - slew bit picks 2 or 4 us per step
// - slew fuse-loaded, writable, ignored when fuse selects
// - buck2 bit 5 forces pwm while scaling downward
// - buck1 bit 6 forces pwm always
// - bit 7 set disconnects discharge resistor
// - two-bit current limit field select
// - bit 4 picks on-time or off-time control
// - six-bit run code fuse-loaded then writable
// - standby code used in standby, defaults run
// - sleep code used in sleep, defaults run
// - run enable fuse-loaded, software may clear
// - standby enable defaults to fused run enable
// - sleep enable, clear keeps off in sleep
// - fuse fields load then behave ordinary
// - buck2 bits 6 and 7 as buck1
module bkreg_top (
    input  wire       clock,
    input  wire       srst,
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata_q,
    input  wire [1:0] power_mode,
    input  wire       fuse_load,
    input  wire [7:0] fuse_b1_ctrl,
    input  wire [7:0] fuse_b1_ilim,
    input  wire [5:0] fuse_b2_volt,
    input  wire [7:0] fuse_b2_ctrl,
    input  wire       fuse_buck1_scaling_select,
    input  wire       fuse_buck2_scaling_select,
    output reg        buck1_on_q,
    output reg        buck1_low_power_q,
    output reg        buck1_slow_slew_q,
    output reg        buck1_pwm_q,
    output reg        buck1_discharge_on_q,
    output reg  [1:0] buck1_current_limit_q,
    output reg        buck1_toff_q,
    output reg        buck2_on_q,
    output reg        buck2_low_power_q,
    output reg  [5:0] buck2_voltage_q,
    output reg        buck2_pwm_q,
    output reg        buck2_discharge_on_q
);
    // ----------------------------------------------------------
    // registers
    // ----------------------------------------------------------
    reg  [7:0] b1_ctrl_q;
    reg  [7:0] b1_ilim_q;
    reg  [5:0] b2_run_q;
    reg  [5:0] b2_stby_q;
    reg  [5:0] b2_slp_q;
    reg  [7:0] b2_ctrl_q;
    reg  [1:0] mode_s1_q;
    reg  [1:0] mode_q;
    reg        ramp_load_q;
    reg  [5:0] b2_target;
    wire [5:0] b2_code;
    wire       b2_down;
    wire       b2_slow;
    reg        b2_off;
    reg        b1_off;
    wire       in_low;
    // named control fields; buck1 bit 5 is stored only, it has no ramp
    wire       buck1_run_enable;
    wire       buck1_standby_enable;
    wire       buck1_sleep_enable;
    wire       buck1_low_power_en;
    wire       buck1_scaling_slew_sel;
    wire       buck1_forced_pwm;
    wire       buck1_discharge_res_off;
    wire [1:0] buck1_current_limit;
    wire       buck1_timing_scheme_sel;
    wire       buck2_run_enable;
    wire       buck2_standby_enable;
    wire       buck2_sleep_enable;
    wire       buck2_low_power_en;
    wire       buck2_scaling_slew_sel;
    wire       buck2_forced_pwm_scale_down;
    wire       buck2_forced_pwm;
    wire       buck2_discharge_res_off;

    // mode pins cross in from the sequencer, two stages
    always @(posedge clock) begin
        if (srst) begin
            mode_s1_q <= `BKREG_MODE_RUN;
            mode_q    <= `BKREG_MODE_RUN;
        end else begin
            mode_s1_q <= power_mode;
            mode_q    <= mode_s1_q;
        end
    end

    // ----------------------------------------------------------
    // register writes and fuse load
    // ----------------------------------------------------------
    // fuse load wins over a write in the same cycle so boot is clean
    always @(posedge clock) begin
        if (srst) begin
            b1_ctrl_q   <= 8'h00;
            b1_ilim_q   <= 8'h00;
            b2_run_q    <= 6'h00;
            b2_stby_q   <= 6'h00;
            b2_slp_q    <= 6'h00;
            b2_ctrl_q   <= 8'h00;
            ramp_load_q <= 1'b0;
        end else if (fuse_load) begin
            b1_ctrl_q   <= {fuse_b1_ctrl[7:2],
                            fuse_b1_ctrl[`BKREG_CTRL_RUN_EN],
                            fuse_b1_ctrl[`BKREG_CTRL_RUN_EN]};
            b1_ilim_q   <= fuse_b1_ilim & `BKREG_ILIM_MASK;
            b2_run_q    <= fuse_b2_volt;
            b2_stby_q   <= fuse_b2_volt;
            b2_slp_q    <= fuse_b2_volt;
            b2_ctrl_q   <= {fuse_b2_ctrl[7:2],
                            fuse_b2_ctrl[`BKREG_CTRL_RUN_EN],
                            fuse_b2_ctrl[`BKREG_CTRL_RUN_EN]};
            ramp_load_q <= 1'b1;
        end else begin
            ramp_load_q <= 1'b0;
            if (reg_wr) begin
                case (reg_addr)
                    `BKREG_ADDR_B1_CTRL: begin
                        b1_ctrl_q <= reg_wdata;
                    end
                    `BKREG_ADDR_B1_ILIM: begin
                        b1_ilim_q <= reg_wdata & `BKREG_ILIM_MASK;
                    end
                    `BKREG_ADDR_B2_RUN_V: begin
                        b2_run_q <= reg_wdata[5:0];
                    end
                    `BKREG_ADDR_B2_STBY_V: begin
                        b2_stby_q <= reg_wdata[5:0];
                    end
                    `BKREG_ADDR_B2_SLP_V: begin
                        b2_slp_q <= reg_wdata[5:0];
                    end
                    `BKREG_ADDR_B2_CTRL: begin
                        b2_ctrl_q <= reg_wdata;
                    end
                    default: begin
                        b1_ctrl_q <= b1_ctrl_q;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------
    // read port
    // ----------------------------------------------------------
    // unmapped addresses and unused bits read as zero
    always @(posedge clock) begin
        if (srst) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `BKREG_ADDR_B1_CTRL:   reg_rdata_q <= b1_ctrl_q;
                `BKREG_ADDR_B1_ILIM:   reg_rdata_q <= b1_ilim_q;
                `BKREG_ADDR_B2_RUN_V:  reg_rdata_q <= {2'h0, b2_run_q};
                `BKREG_ADDR_B2_STBY_V: reg_rdata_q <= {2'h0, b2_stby_q};
                `BKREG_ADDR_B2_SLP_V:  reg_rdata_q <= {2'h0, b2_slp_q};
                `BKREG_ADDR_B2_CTRL:   reg_rdata_q <= b2_ctrl_q;
                default:               reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------
    // buck2 voltage target and ramp
    // ----------------------------------------------------------
    // pick the code for the current power mode
    always @* begin
        case (mode_q)
            `BKREG_MODE_STBY: b2_target = b2_stby_q;
            `BKREG_MODE_SLP:  b2_target = b2_slp_q;
            default:          b2_target = b2_run_q;
        endcase
    end

    // fused scaling select overrides the slew bit
    assign b2_slow = buck2_scaling_slew_sel
                     & ~fuse_buck2_scaling_select;

    // one ramp only: buck1 voltage registers live outside this bank
    bkreg_ramp #(
        .W      (6)
    ) u_b2_ramp (
        .clock  (clock),
        .srst   (srst),
        .load   (ramp_load_q),
        .target (b2_target),
        .slow   (b2_slow),
        .code_q (b2_code),
        .down_q (b2_down)
    );

    // ----------------------------------------------------------
    // regulator controls
    // ----------------------------------------------------------
    assign in_low = (mode_q == `BKREG_MODE_STBY)
                    | (mode_q == `BKREG_MODE_SLP);

    // ----------------------------------------------------------
    // control fields
    // ----------------------------------------------------------
    // buck1 control and current-limit fields
    // limit code 0 to 3 picks 1.0, 1.2, 1.5 or 2.0 A typical
    assign buck1_run_enable        = b1_ctrl_q[`BKREG_CTRL_RUN_EN];
    assign buck1_standby_enable    = b1_ctrl_q[`BKREG_CTRL_STBY_EN];
    assign buck1_sleep_enable      = b1_ctrl_q[`BKREG_CTRL_SLP_EN];
    assign buck1_low_power_en      = b1_ctrl_q[`BKREG_CTRL_LPWR];
    assign buck1_scaling_slew_sel  = b1_ctrl_q[`BKREG_CTRL_SLEW];
    assign buck1_forced_pwm        = b1_ctrl_q[`BKREG_CTRL_FPWM];
    assign buck1_discharge_res_off = b1_ctrl_q[`BKREG_CTRL_RDIS_OFF];
    assign buck1_current_limit     = b1_ilim_q[1:0];
    assign buck1_timing_scheme_sel = b1_ilim_q[`BKREG_ILIM_TMODE];

    // buck2 fields, same layout; bit 5 feeds the ramp force below
    assign buck2_run_enable            = b2_ctrl_q[`BKREG_CTRL_RUN_EN];
    assign buck2_standby_enable        = b2_ctrl_q[`BKREG_CTRL_STBY_EN];
    assign buck2_sleep_enable          = b2_ctrl_q[`BKREG_CTRL_SLP_EN];
    assign buck2_low_power_en          = b2_ctrl_q[`BKREG_CTRL_LPWR];
    assign buck2_scaling_slew_sel      = b2_ctrl_q[`BKREG_CTRL_SLEW];
    assign buck2_forced_pwm_scale_down = b2_ctrl_q[`BKREG_CTRL_FPWM_DN];
    assign buck2_forced_pwm            = b2_ctrl_q[`BKREG_CTRL_FPWM];
    assign buck2_discharge_res_off     = b2_ctrl_q[`BKREG_CTRL_RDIS_OFF];

    // ----------------------------------------------------------
    // regulator controls
    // ----------------------------------------------------------
    // enable per mode; code 3 falls through to run as in the target pick
    always @* begin
        case (mode_q)
            `BKREG_MODE_STBY: begin
                b1_off = ~buck1_standby_enable;
                b2_off = ~buck2_standby_enable;
            end
            `BKREG_MODE_SLP: begin
                b1_off = ~buck1_sleep_enable;
                b2_off = ~buck2_sleep_enable;
            end
            default: begin
                b1_off = ~buck1_run_enable;
                b2_off = ~buck2_run_enable;
            end
        endcase
    end

    // buck1 outputs; no ramp here, only its rate leaves the bank
    always @(posedge clock) begin
        if (srst) begin
            buck1_on_q            <= 1'b0;
            buck1_low_power_q     <= 1'b0;
            buck1_slow_slew_q     <= 1'b0;
            buck1_pwm_q           <= 1'b0;
            buck1_discharge_on_q  <= 1'b0;
            buck1_current_limit_q <= 2'h0;
            buck1_toff_q          <= 1'b0;
        end else begin
            buck1_on_q            <= ~b1_off;
            buck1_low_power_q     <= in_low & buck1_low_power_en;
            buck1_slow_slew_q     <= buck1_scaling_slew_sel
                                     & ~fuse_buck1_scaling_select;
            buck1_pwm_q           <= buck1_forced_pwm;
            buck1_discharge_on_q  <= b1_off
                                     & ~buck1_discharge_res_off;
            buck1_current_limit_q <= buck1_current_limit;
            buck1_toff_q          <= buck1_timing_scheme_sel;
        end
    end

    // buck2 outputs; pwm is forced while the ramp steps down
    always @(posedge clock) begin
        if (srst) begin
            buck2_on_q            <= 1'b0;
            buck2_low_power_q     <= 1'b0;
            buck2_voltage_q       <= 6'h00;
            buck2_pwm_q           <= 1'b0;
            buck2_discharge_on_q  <= 1'b0;
        end else begin
            buck2_on_q            <= ~b2_off;
            buck2_low_power_q     <= in_low
                                     & buck2_low_power_en;
            buck2_voltage_q       <= b2_code;
            buck2_pwm_q           <= buck2_forced_pwm
                                     | (b2_down
                                     & buck2_forced_pwm_scale_down);
            buck2_discharge_on_q  <= b2_off
                                     & ~buck2_discharge_res_off;
        end
    end
endmodule

/* tb/bkreg_top_monitor.sv */
// port assertions for the buck control register bank
// assumes bound into bkreg_top: one clock, sync active-high reset
`timescale 1ns/100ps
`include "bkreg_map.vh"
module bkreg_mon (
    input wire logic       clock,
    input wire logic       srst,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_q,
    input wire logic [1:0] power_mode,
    input wire logic       fuse_load,
    input wire logic       fuse_buck1_scaling_select,
    input wire logic       buck1_on_q,
    input wire logic       buck1_low_power_q,
    input wire logic       buck1_slow_slew_q,
    input wire logic       buck1_pwm_q,
    input wire logic       buck1_discharge_on_q,
    input wire logic [1:0] buck1_current_limit_q,
    input wire logic       buck1_toff_q
);
    wire logic volt_a;
    wire logic known_a;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // ------------------------------------------------------------
    // address decode and access sequences
    // ------------------------------------------------------------
    assign volt_a = reg_addr >= 8'h38 && reg_addr <= 8'h3A;
    assign known_a = volt_a || reg_addr == 8'h35 || reg_addr == 8'h36
                     || reg_addr == 8'h3B;
    // fuse loading wins over a same-cycle write, so exclude it
    sequence s_wr(a); reg_wr && !fuse_load && reg_addr == a; endsequence
    sequence s_rd(a); reg_rd && reg_addr == a; endsequence
    AST_ILIM: assert property (s_wr(8'h36) |-> ##2
        buck1_current_limit_q == $past(reg_wdata[1:0], 2)) else $error("ilim");
    AST_TOFF: assert property (s_wr(8'h36) |-> ##2
        buck1_toff_q == $past(reg_wdata[4], 2)) else $error("toff");
    AST_FPWM: assert property (s_wr(8'h35) |-> ##2
        buck1_pwm_q == $past(reg_wdata[6], 2)) else $error("fpwm");
    AST_RD_ILIM: assert property (s_rd(8'h36) |=>
        (reg_rdata_q & 8'hEC) == 8'h00) else $error("ilim spare bits");
    AST_RD_VOLT: assert property (reg_rd && volt_a |=>
        reg_rdata_q[7:6] == 2'h0) else $error("volt spare bits");
    AST_UNMAPPED: assert property (reg_rd && !known_a |=>
        reg_rdata_q == 8'h00) else $error("unmapped read");
    AST_RD_HOLD: assert property (!reg_rd |=>
        $stable(reg_rdata_q)) else $error("read data moved");
    AST_LP_RUN: assert property (power_mode == 2'h0 [*4] |->
        !buck1_low_power_q) else $error("low power in run");
    AST_SLEW_FUSE: assert property (fuse_buck1_scaling_select [*3] |->
        !buck1_slow_slew_q) else $error("slew not ignored");
    AST_DIS: assert property (buck1_discharge_on_q |->
        !buck1_on_q) else $error("discharge while on");
endmodule
bind bkreg_top bkreg_mon u_mon (.clock, .srst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata_q, .power_mode, .fuse_load,
    .fuse_buck1_scaling_select, .buck1_on_q, .buck1_low_power_q,
    .buck1_slow_slew_q, .buck1_pwm_q, .buck1_discharge_on_q,
    .buck1_current_limit_q, .buck1_toff_q);

/* tb/bkreg_top_tb.sv */
// self-checking bench for the buck control register bank
// assumes bkreg_top alone; inputs change on the falling clock edge
`timescale 1ns/100ps
module bkreg_top_tb;
    logic       clock, srst, reg_wr, reg_rd, fuse_load;
    logic       fuse_buck1_scaling_select, fuse_buck2_scaling_select;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
    logic [7:0] fuse_b1_ctrl, fuse_b1_ilim, fuse_b2_ctrl;
    logic [5:0] fuse_b2_volt, buck2_voltage_q;
    logic [1:0] power_mode, buck1_current_limit_q;
    logic       buck1_on_q, buck1_low_power_q, buck1_slow_slew_q;
    logic       buck1_pwm_q, buck1_discharge_on_q, buck1_toff_q;
    logic       buck2_on_q, buck2_low_power_q, buck2_pwm_q;
    logic       buck2_discharge_on_q;
    int         err_count, num_checks;
    logic [7:0] en_bits;
    // enable, low-power and discharge of both bucks, buck1 above
    assign en_bits = {2'h0, buck1_on_q, buck1_low_power_q,
        buck1_discharge_on_q, buck2_on_q, buck2_low_power_q,
        buck2_discharge_on_q};
    // address, data written, value read back; 0x37 is unmapped
    logic [7:0] rows [7][3] = '{'{8'h35, 8'hFF, 8'hFF},
        '{8'h36, 8'hFF, 8'h13}, '{8'h38, 8'hFF, 8'h3F},
        '{8'h39, 8'h2A, 8'h2A}, '{8'h3A, 8'h15, 8'h15},
        '{8'h3B, 8'h5A, 8'h5A}, '{8'h37, 8'hFF, 8'h00}};
    bkreg_top u_dut (.clock, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata_q, .power_mode, .fuse_load, .fuse_b1_ctrl, .fuse_b1_ilim,
        .fuse_b2_volt, .fuse_b2_ctrl, .fuse_buck1_scaling_select,
        .fuse_buck2_scaling_select, .buck1_on_q, .buck1_low_power_q,
        .buck1_slow_slew_q, .buck1_pwm_q, .buck1_discharge_on_q,
        .buck1_current_limit_q, .buck1_toff_q, .buck2_on_q,
        .buck2_low_power_q, .buck2_voltage_q, .buck2_pwm_q,
        .buck2_discharge_on_q);
    // ------------------------------------------------------------
    // clock, checking and register access tasks
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // one-cycle strobe, released on the next falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        chk(reg_rdata_q, exp);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // whole run is near 1000 cycles; allow forty times that
    initial begin
        #400000;
        err_count++;
        end_sim();
    end
    initial begin
        {srst, reg_wr, reg_rd, fuse_load} = 4'h8;
        {fuse_buck1_scaling_select, fuse_buck2_scaling_select} = 2'h0;
        {reg_addr, reg_wdata, fuse_b1_ctrl, fuse_b1_ilim} = 32'h0;
        {fuse_b2_ctrl, fuse_b2_volt, power_mode} = 16'h0;
        cyc(20);
        srst = 1'b0;
        rdchk(8'h3B, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i][0], rows[i][1]);
            rdchk(rows[i][0], rows[i][2]);
        end
        cyc(2);
        chk({buck1_pwm_q, buck1_slow_slew_q, buck1_toff_q, 3'h0,
             buck1_current_limit_q}, 8'hE3);
        fuse_buck1_scaling_select = 1'b1;
        cyc(3);
        chk({7'h0, buck1_slow_slew_q}, 8'h00);
        // fuse image: run code 0x2A, run enables, buck1 low power and slew
        fuse_b2_volt = 6'h2A;
        fuse_b2_ctrl = 8'h01;
        fuse_b1_ctrl = 8'h19;
        fuse_b1_ilim = 8'hFE;
        fuse_load = 1'b1;
        cyc(1);
        fuse_load = 1'b0;
        rdchk(8'h39, 8'h2A);
        rdchk(8'h3A, 8'h2A);
        rdchk(8'h3B, 8'h03);
        rdchk(8'h35, 8'h1B);
        rdchk(8'h36, 8'h12);
        chk({buck2_on_q, 1'b0, buck2_voltage_q}, 8'hAA);
        wr(8'h3B, 8'h2A);
        cyc(2);
        chk(en_bits, 8'h21);
        power_mode = 2'h1;
        cyc(6);
        chk(en_bits, 8'h36);
        power_mode = 2'h2;
        cyc(6);
        chk(en_bits, 8'h1B);
        // code 3 is decoded as run
        power_mode = 2'h3;
        cyc(6);
        chk(en_bits, 8'h21);
        power_mode = 2'h0;
        cyc(6);
        // one step down, fast then slow slew
        wr(8'h38, 8'h29);
        cyc(100);
        chk({buck2_pwm_q, 1'b0, buck2_voltage_q}, 8'hAA);
        cyc(120);
        chk({buck2_pwm_q, 1'b0, buck2_voltage_q}, 8'h29);
        wr(8'h3B, 8'h3A);
        wr(8'h38, 8'h28);
        cyc(300);
        chk({buck2_pwm_q, 1'b0, buck2_voltage_q}, 8'hA9);
        cyc(150);
        chk({buck2_pwm_q, 1'b0, buck2_voltage_q}, 8'h28);
        fuse_buck2_scaling_select = 1'b1;
        wr(8'h38, 8'h27);
        cyc(220);
        chk({2'h0, buck2_voltage_q}, 8'h27);
        wr(8'h3B, 8'hC0);
        cyc(3);
        chk({6'h0, buck2_pwm_q, buck2_discharge_on_q}, 8'h02);
        // reset in mid-run clears every register and output
        srst = 1'b1;
        cyc(2);
        chk(en_bits, 8'h00);
        chk({2'h0, buck2_voltage_q}, 8'h00);
        srst = 1'b0;
        rdchk(8'h35, 8'h00);
        rdchk(8'h38, 8'h00);
        chk(en_bits, 8'h09);
        end_sim();
    end
endmodule
